// file: inc/fpvss_defines.svh
// How it works
// - control word goes in bytes 1:0
// - status word goes in bytes 3:2
// - abridged tag at byte 4, byte 5 zero
// - opcode in bytes 7:6, low 11 bits
// - instruction pointer 32 bits, 16-bit mode masked
// - code selector at bytes 13:12 when narrow
// - operand pointer 32 bits, 16-bit mode masked
// - data selector stored beside operand pointer
// - vector status saved, skipped when save disabled
// - writable mask of vector status always saved
// - eight 80-bit data registers, one row each
// - packed-integer state zeroes top 16 bits
// - vector registers 128 bits, skipped when disabled
// - compatibility mode saves first eight vectors only
// - 64-bit mode saves sixteen, prefix picks layout
// - wide prefix: 64-bit pointers, no selectors
// - narrow prefix: 32-bit pointers
// - wide layout offsets; bytes from 464 untouched
// - narrow layout offsets for selector, status, mask
// - restore ignores bytes 464 to 511
// - restore faults on reserved status bit set
`ifndef FPVSS_DEFINES_SVH
`define FPVSS_DEFINES_SVH

// image rows of 16 bytes
`define FPVSS_ROW_CTRL 5'h00
`define FPVSS_ROW_PTR 5'h01
`define FPVSS_ROW_DATA0 5'h02
`define FPVSS_ROW_VEC0 5'h0A
`define FPVSS_ROW_VEC8 5'h12
`define FPVSS_ROW_VEC_END 5'h19
`define FPVSS_ROW_LAST 5'h1C
`define FPVSS_OPCODE_BITS 11
`define FPVSS_EMPTY_TAG 2'h3
`define FPVSS_VCSR_RST 32'h00000000

`endif

// file: inc/fpvss_pkg.sv
package fpvss_pkg;
    typedef logic [7:0][79:0] fpvss_data_regs_t;
    typedef logic [15:0][127:0] fpvss_vec_regs_t;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_SAVE = 4'h2,
        ST_RREQ = 4'h4,
        ST_RWAIT = 4'h8
    } fpvss_state_e;
endpackage

// file: hdl/fpvss_tag_abridge.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpvss_defines.svh"
module fpvss_tag_abridge (
    // full two-bit tags of eight data registers
    input wire logic [15:0] full_tag,
    // abridged form
    output logic [7:0] abridged_tag_byte
);
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_tag
            assign abridged_tag_byte[i] = (full_tag[2*i+1:2*i] != `FPVSS_EMPTY_TAG);
        end
    endgenerate
endmodule
`default_nettype wire

// file: hdl/fpvss_row_builder.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpvss_defines.svh"
module fpvss_row_builder (
    // row select and latched mode
    input wire logic [4:0] row,
    input wire logic wide,
    input wire logic mode64,
    input wire logic addr16,
    input wire logic os_save,
    input wire logic packed_last,
    // state fields
    input wire logic [15:0] fp_control_word,
    input wire logic [15:0] fp_status_word,
    input wire logic [7:0] abridged_tag_byte,
    input wire logic [10:0] last_fp_opcode,
    input wire logic [63:0] fp_instruction_pointer,
    input wire logic [15:0] code_selector,
    input wire logic [63:0] fp_operand_pointer,
    input wire logic [15:0] data_selector,
    input wire logic [31:0] vector_control_status,
    input wire logic [31:0] vector_control_writable_mask,
    input wire fpvss_pkg::fpvss_data_regs_t data_register_field,
    input wire fpvss_pkg::fpvss_vec_regs_t vector_register_field,
    // row image and byte strobes
    output logic [127:0] data,
    output logic [15:0] strb
);
    logic [4:0] doff;
    logic [4:0] voff;
    assign doff = row - `FPVSS_ROW_DATA0;
    assign voff = row - `FPVSS_ROW_VEC0;

    always_comb begin
        data = '0;
        strb = 16'hFFFF;
        if (row == `FPVSS_ROW_CTRL) begin
            data[15:0] = fp_control_word;
            data[31:16] = fp_status_word;
            data[39:32] = abridged_tag_byte;
            data[48 +: `FPVSS_OPCODE_BITS] = last_fp_opcode;
            if (wide) begin
                data[127:64] = fp_instruction_pointer;
            end else begin
                data[79:64] = fp_instruction_pointer[15:0];
                if (!addr16) begin
                    data[95:80] = fp_instruction_pointer[31:16];
                end
                data[111:96] = code_selector;
            end
        end else if (row == `FPVSS_ROW_PTR) begin
            if (wide) begin
                data[63:0] = fp_operand_pointer;
            end else begin
                data[15:0] = fp_operand_pointer[15:0];
                if (!addr16) begin
                    data[31:16] = fp_operand_pointer[31:16];
                end
                data[47:32] = data_selector;
            end
            data[95:64] = vector_control_status;
            data[127:96] = vector_control_writable_mask;
            if (!os_save) begin
                strb[11:8] = 4'h0;
            end
        end else if (row >= `FPVSS_ROW_DATA0 && row < `FPVSS_ROW_VEC0) begin
            data[79:0] = data_register_field[doff[2:0]];
            if (packed_last) begin
                data[79:64] = 16'h0000;
            end
        end else if (row >= `FPVSS_ROW_VEC0 && row <= `FPVSS_ROW_VEC_END) begin
            if (mode64 || row < `FPVSS_ROW_VEC8) begin
                data = vector_register_field[voff[3:0]];
            end
            if (!os_save) begin
                strb = 16'h0000;
            end
        end
    end
endmodule
`default_nettype wire

// file: hdl/fpvss_state_image.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpvss_defines.svh"
module fpvss_state_image (
    input wire logic clk,
    input wire logic sys_rst,
    // commands from the core
    input wire logic state_save_op,
    input wire logic state_restore_op,
    input wire logic operand_width_prefix_bit,
    input wire logic mode64,
    input wire logic addr16,
    input wire logic os_save_enable_bit,
    input wire logic packed_last,
    input wire logic [63:0] image_base,
    // state to save
    input wire logic [15:0] fp_control_word,
    input wire logic [15:0] fp_status_word,
    input wire logic [15:0] fp_full_tag,
    input wire logic [10:0] last_fp_opcode,
    input wire logic [63:0] fp_instruction_pointer,
    input wire logic [15:0] code_selector,
    input wire logic [63:0] fp_operand_pointer,
    input wire logic [15:0] data_selector,
    input wire logic [31:0] vector_control_status,
    input wire logic [31:0] vector_control_writable_mask,
    input wire fpvss_pkg::fpvss_data_regs_t data_register_field,
    input wire fpvss_pkg::fpvss_vec_regs_t vector_register_field,
    // memory write stream
    output logic mem_wr_valid,
    input wire logic mem_wr_ready,
    output logic [63:0] mem_wr_addr,
    output logic [127:0] mem_wr_data,
    output logic [15:0] mem_wr_strb,
    // memory read
    output logic mem_rd_valid,
    input wire logic mem_rd_ready,
    output logic [63:0] mem_rd_addr,
    input wire logic mem_rd_resp_valid,
    input wire logic [127:0] mem_rd_data,
    // status to the core
    output logic busy,
    output logic save_done,
    output logic restore_done,
    output logic gp_fault,
    output logic [31:0] restored_vector_control_status
);
    ////////////////////////////////////////////////////////////////////////
    fpvss_pkg::fpvss_state_e st, next_st;
    logic [4:0] row, next_row;
    logic [4:0] wr_row, next_wr_row;
    logic wide, next_wide;
    logic m64, next_m64;
    logic a16, next_a16;
    logic os_q, next_os_q;
    logic pk, next_pk;
    logic next_mem_wr_valid;
    logic [63:0] next_mem_wr_addr;
    logic [127:0] next_mem_wr_data;
    logic [15:0] next_mem_wr_strb;
    logic next_mem_rd_valid;
    logic [63:0] next_mem_rd_addr;
    logic next_busy;
    logic next_save_done;
    logic next_restore_done;
    logic next_gp_fault;
    logic [31:0] next_restored;
    logic [7:0] tag_byte;
    logic [127:0] row_data;
    logic [15:0] row_strb;
    logic issue;
    logic rsvd_hit;

    fpvss_tag_abridge u_tag (
        .full_tag(fp_full_tag),
        .abridged_tag_byte(tag_byte)
    );

    fpvss_row_builder u_row (
        .row(row),
        .wide(wide),
        .mode64(m64),
        .addr16(a16),
        .os_save(os_q),
        .packed_last(pk),
        .fp_control_word(fp_control_word),
        .fp_status_word(fp_status_word),
        .abridged_tag_byte(tag_byte),
        .last_fp_opcode(last_fp_opcode),
        .fp_instruction_pointer(fp_instruction_pointer),
        .code_selector(code_selector),
        .fp_operand_pointer(fp_operand_pointer),
        .data_selector(data_selector),
        .vector_control_status(vector_control_status),
        .vector_control_writable_mask(vector_control_writable_mask),
        .data_register_field(data_register_field),
        .vector_register_field(vector_register_field),
        .data(row_data),
        .strb(row_strb)
    );

    ////////////////////////////////////////////////////////////////////////
    // a row may be loaded when the output register is empty or draining
    assign issue = !mem_wr_valid || mem_wr_ready;
    // bits outside the writable mask are reserved
    assign rsvd_hit = |(mem_rd_data[95:64] & ~vector_control_writable_mask);

    always_comb begin
        next_st = st;
        next_row = row;
        next_wr_row = wr_row;
        next_wide = wide;
        next_m64 = m64;
        next_a16 = a16;
        next_os_q = os_q;
        next_pk = pk;
        next_mem_wr_valid = mem_wr_valid;
        next_mem_wr_addr = mem_wr_addr;
        next_mem_wr_data = mem_wr_data;
        next_mem_wr_strb = mem_wr_strb;
        next_mem_rd_valid = mem_rd_valid;
        next_mem_rd_addr = mem_rd_addr;
        next_busy = busy;
        next_save_done = 1'b0;
        next_restore_done = 1'b0;
        next_gp_fault = 1'b0;
        next_restored = restored_vector_control_status;
        unique case (st)
            fpvss_pkg::ST_IDLE: begin
                // mode is frozen at the command so a mid-save change cannot mix layouts
                next_wide = mode64 & operand_width_prefix_bit;
                next_m64 = mode64;
                next_a16 = addr16 & ~(mode64 & operand_width_prefix_bit);
                next_os_q = os_save_enable_bit;
                next_pk = packed_last;
                if (state_save_op) begin
                    next_st = fpvss_pkg::ST_SAVE;
                    next_row = `FPVSS_ROW_CTRL;
                    next_busy = 1'b1;
                end else if (state_restore_op) begin
                    next_st = fpvss_pkg::ST_RREQ;
                    next_busy = 1'b1;
                    next_mem_rd_valid = 1'b1;
                    // only the status row is fetched; software bytes never are
                    next_mem_rd_addr = {image_base[63:4] + 60'(`FPVSS_ROW_PTR), 4'h0};
                end
            end
            fpvss_pkg::ST_SAVE: begin
                if (issue) begin
                    if (row <= `FPVSS_ROW_LAST) begin
                        next_mem_wr_valid = 1'b1;
                        next_mem_wr_data = row_data;
                        next_mem_wr_strb = row_strb;
                        next_mem_wr_addr = {image_base[63:4] + 60'(row), 4'h0};
                        next_wr_row = row;
                        next_row = row + 5'h01;
                    end else begin
                        // rows from 29 (byte 464) on are left to software
                        next_mem_wr_valid = 1'b0;
                        next_st = fpvss_pkg::ST_IDLE;
                        next_busy = 1'b0;
                        next_save_done = 1'b1;
                    end
                end
            end
            fpvss_pkg::ST_RREQ: begin
                if (mem_rd_ready) begin
                    next_mem_rd_valid = 1'b0;
                    next_st = fpvss_pkg::ST_RWAIT;
                end
            end
            fpvss_pkg::ST_RWAIT: begin
                if (mem_rd_resp_valid) begin
                    next_gp_fault = rsvd_hit;
                    if (!rsvd_hit && os_q) begin
                        next_restored = mem_rd_data[95:64];
                    end
                    next_restore_done = 1'b1;
                    next_busy = 1'b0;
                    next_st = fpvss_pkg::ST_IDLE;
                end
            end
            default: begin
                next_st = fpvss_pkg::ST_IDLE;
                next_busy = 1'b0;
                next_mem_wr_valid = 1'b0;
                next_mem_rd_valid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= fpvss_pkg::ST_IDLE;
            row <= 5'h00;
            wr_row <= 5'h00;
            wide <= 1'b0;
            m64 <= 1'b0;
            a16 <= 1'b0;
            os_q <= 1'b0;
            pk <= 1'b0;
            mem_wr_valid <= 1'b0;
            mem_wr_addr <= 64'h0;
            mem_wr_data <= 128'h0;
            mem_wr_strb <= 16'h0000;
            mem_rd_valid <= 1'b0;
            mem_rd_addr <= 64'h0;
            busy <= 1'b0;
            save_done <= 1'b0;
            restore_done <= 1'b0;
            gp_fault <= 1'b0;
            restored_vector_control_status <= `FPVSS_VCSR_RST;
        end else begin
            st <= next_st;
            row <= next_row;
            wr_row <= next_wr_row;
            wide <= next_wide;
            m64 <= next_m64;
            a16 <= next_a16;
            os_q <= next_os_q;
            pk <= next_pk;
            mem_wr_valid <= next_mem_wr_valid;
            mem_wr_addr <= next_mem_wr_addr;
            mem_wr_data <= next_mem_wr_data;
            mem_wr_strb <= next_mem_wr_strb;
            mem_rd_valid <= next_mem_rd_valid;
            mem_rd_addr <= next_mem_rd_addr;
            busy <= next_busy;
            save_done <= next_save_done;
            restore_done <= next_restore_done;
            gp_fault <= next_gp_fault;
            restored_vector_control_status <= next_restored;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // accepted beats of the current save; a long repetition would be too costly to unroll
    logic [5:0] save_beats, next_save_beats;

    always_comb begin
        next_save_beats = save_beats;
        if (st == fpvss_pkg::ST_IDLE && state_save_op) begin
            next_save_beats = 6'h00;
        end else if (st == fpvss_pkg::ST_SAVE && mem_wr_valid && mem_wr_ready) begin
            next_save_beats = save_beats + 6'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            save_beats <= 6'h00;
        end else begin
            save_beats <= next_save_beats;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_row0_load;
        st == fpvss_pkg::ST_SAVE && issue && row == `FPVSS_ROW_CTRL;
    endsequence

    sequence s_row0_out;
        mem_wr_valid && wr_row == `FPVSS_ROW_CTRL;
    endsequence

    sequence s_resp_bad;
        st == fpvss_pkg::ST_RWAIT && mem_rd_resp_valid && rsvd_hit;
    endsequence

    a_tag_abridged: assert property (@(posedge clk) disable iff (sys_rst)
        s_row0_load |=> mem_wr_data[39:32] == $past(tag_byte) && mem_wr_data[47:40] == 8'h00)
        else $error("abridged tag byte wrong");

    a_ctrl_status_words: assert property (@(posedge clk) disable iff (sys_rst)
        s_row0_load |=> mem_wr_data[31:0] == {$past(fp_status_word), $past(fp_control_word)})
        else $error("control or status word misplaced");

    a_opcode_reserved: assert property (@(posedge clk) disable iff (sys_rst)
        s_row0_out |-> mem_wr_data[63:59] == 5'h00)
        else $error("opcode reserved bits set");

    a_narrow_top_zero: assert property (@(posedge clk) disable iff (sys_rst)
        s_row0_out and !wide |-> mem_wr_data[127:112] == 16'h0000)
        else $error("narrow layout top bytes not zero");

    a_packed_high_zero: assert property (@(posedge clk) disable iff (sys_rst)
        mem_wr_valid && pk && wr_row >= `FPVSS_ROW_DATA0 && wr_row < `FPVSS_ROW_VEC0
        |-> mem_wr_data[127:64] == 64'h0)
        else $error("packed register high bits not zero");

    a_vec_omitted: assert property (@(posedge clk) disable iff (sys_rst)
        mem_wr_valid && !os_q && wr_row >= `FPVSS_ROW_VEC0 && wr_row <= `FPVSS_ROW_VEC_END
        |-> mem_wr_strb == 16'h0000)
        else $error("vector row written with save disabled");

    a_compat_upper: assert property (@(posedge clk) disable iff (sys_rst)
        mem_wr_valid && !m64 && wr_row >= `FPVSS_ROW_VEC8 && wr_row <= `FPVSS_ROW_VEC_END
        |-> mem_wr_data == 128'h0)
        else $error("upper vectors saved outside 64-bit mode");

    a_no_avail_write: assert property (@(posedge clk) disable iff (sys_rst)
        mem_wr_valid |-> wr_row <= `FPVSS_ROW_LAST)
        else $error("software area written");

    a_restore_row: assert property (@(posedge clk) disable iff (sys_rst)
        mem_rd_valid |-> mem_rd_addr == {image_base[63:4], 4'h0} + 64'h10)
        else $error("restore fetched a row other than status row");

    a_gp_fault: assert property (@(posedge clk) disable iff (sys_rst)
        s_resp_bad |=> gp_fault && restore_done && $stable(restored_vector_control_status))
        else $error("reserved status bit did not fault");

    a_save_beats: assert property (@(posedge clk) disable iff (sys_rst)
        save_done |-> save_beats == 6'(`FPVSS_ROW_LAST) + 6'h01)
        else $error("save did not write every image row");
endmodule
`default_nettype wire

// file: bench/fpvss_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module fpvss_mem_model (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // stall select from the bench
    input wire logic slow,
    // write stream
    input wire logic mem_wr_valid,
    output logic mem_wr_ready,
    input wire logic [63:0] mem_wr_addr,
    input wire logic [127:0] mem_wr_data,
    input wire logic [15:0] mem_wr_strb,
    // read port
    input wire logic mem_rd_valid,
    output logic mem_rd_ready,
    input wire logic [63:0] mem_rd_addr,
    output logic mem_rd_resp_valid,
    output logic [127:0] mem_rd_data
);
    // image indexed by row; the base must sit on a 512-byte boundary
    logic [127:0] img [0:31];
    int beats;
    logic [63:0] rd_addr_seen;
    logic [1:0] tick;
    logic [1:0] wait_cnt;
    logic pend;

    initial begin
        mem_wr_ready = 1'b0;
        mem_rd_ready = 1'b0;
        mem_rd_resp_valid = 1'b0;
        mem_rd_data = 128'h0;
        beats = 0;
        rd_addr_seen = 64'h0;
        tick = 2'h0;
        wait_cnt = 2'h0;
        pend = 1'b0;
    end

    ////////////////////////////////////////////////////////////////
    always begin
        @(posedge clk);
        if (mem_wr_valid && mem_wr_ready) begin
            for (int b = 0; b < 16; b++)
                if (mem_wr_strb[b]) img[mem_wr_addr[8:4]][b*8 +: 8] = mem_wr_data[b*8 +: 8];
            beats++;
        end
        if (mem_rd_valid && mem_rd_ready) begin
            rd_addr_seen = mem_rd_addr;
            pend = 1'b1;
            wait_cnt = slow ? 2'h3 : 2'h0;
        end
        #1;
        tick = tick + 2'h1;
        // slow mode stalls both ports so held requests are exercised
        mem_wr_ready = !sys_rst && (!slow || tick[1]);
        mem_rd_ready = !sys_rst && (!slow || tick == 2'h3);
        mem_rd_resp_valid = 1'b0;
        if (pend && wait_cnt == 2'h0) begin
            mem_rd_resp_valid = 1'b1;
            mem_rd_data = img[rd_addr_seen[8:4]];
            pend = 1'b0;
        end else begin
            if (pend) wait_cnt = wait_cnt - 2'h1;
            // outside a response the read data is inverted every cycle
            mem_rd_data = ~mem_rd_data;
        end
    end
endmodule
`default_nettype wire

// file: bench/fp_vector_state_save_image_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module fp_vector_state_save_image_test;
    localparam logic [127:0] FILL = {16{8'hA5}};
    logic clk, sys_rst, slow;
    logic state_save_op, state_restore_op, operand_width_prefix_bit, mode64, addr16;
    logic os_save_enable_bit, packed_last;
    logic [63:0] image_base, fp_instruction_pointer, fp_operand_pointer, mem_wr_addr, mem_rd_addr;
    logic [15:0] fp_control_word, fp_status_word, fp_full_tag, code_selector, data_selector, mem_wr_strb;
    logic [10:0] last_fp_opcode;
    logic [31:0] vector_control_status, vector_control_writable_mask, restored_vector_control_status;
    fpvss_pkg::fpvss_data_regs_t data_register_field;
    fpvss_pkg::fpvss_vec_regs_t vector_register_field;
    logic mem_wr_valid, mem_wr_ready, mem_rd_valid, mem_rd_ready, mem_rd_resp_valid;
    logic [127:0] mem_wr_data, mem_rd_data;
    logic busy, save_done, restore_done, gp_fault;
    int bad_count = 0;
    int comparisons = 0;

    fpvss_state_image dut (.*);
    fpvss_mem_model mem (.*);

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////
    function automatic logic [127:0] exp_row(input int r);
        logic [7:0] t;
        logic [31:0] ip32, dp32;
        logic w;
        w = mode64 && operand_width_prefix_bit;
        for (int i = 0; i < 8; i++) t[i] = fp_full_tag[2*i +: 2] != 2'h3;
        ip32 = (addr16 && !w) ? {16'h0000, fp_instruction_pointer[15:0]} : fp_instruction_pointer[31:0];
        dp32 = (addr16 && !w) ? {16'h0000, fp_operand_pointer[15:0]} : fp_operand_pointer[31:0];
        if (r == 0) begin
            exp_row = {w ? fp_instruction_pointer : {16'h0000, code_selector, ip32},
                5'h00, last_fp_opcode, 8'h00, t, fp_status_word, fp_control_word};
        end else if (r == 1) begin
            exp_row = {vector_control_writable_mask, vector_control_status,
                w ? fp_operand_pointer : {16'h0000, data_selector, dp32}};
            if (!os_save_enable_bit) exp_row[95:64] = FILL[95:64];
        end else if (r < 10) begin
            exp_row = {48'h0, packed_last ? 16'h0000 : data_register_field[r-2][79:64],
                data_register_field[r-2][63:0]};
        end else if (r < 26) begin
            exp_row = !os_save_enable_bit ? FILL : (r >= 18 && !mode64) ? 128'h0 : vector_register_field[r-10];
        end else begin
            exp_row = r < 29 ? 128'h0 : FILL;
        end
    endfunction

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic do_save(input string name, input logic m, w, a, o, p, s);
        int n;
        for (int i = 0; i < 32; i++) mem.img[i] = FILL;
        mem.beats = 0;
        mode64 = m;
        operand_width_prefix_bit = w;
        addr16 = a;
        os_save_enable_bit = o;
        packed_last = p;
        slow = s;
        state_save_op = 1'b1;
        @(posedge clk);
        #1;
        state_save_op = 1'b0;
        `CHK("busy", 1'b1, busy)
        n = 0;
        while (save_done !== 1'b1 && n < 300) begin
            // a second command in mid-save must be ignored
            state_save_op = (n == 5);
            @(posedge clk);
            #1;
            n++;
        end
        `CHK("save_done", 1'b1, save_done)
        `CHK("busy", 1'b0, busy)
        `CHK("last addr", image_base + 64'h1C0, mem_wr_addr)
        `CHK("beats", 29, mem.beats)
        `CHK("row0", exp_row(0), mem.img[0])
        `CHK("row1", exp_row(1), mem.img[1])
        for (int r = 2; r < 10; r++) `CHK("data row", exp_row(r), mem.img[r])
        for (int r = 10; r < 26; r++) `CHK("vector row", exp_row(r), mem.img[r])
        for (int r = 26; r < 32; r++) `CHK("tail row", exp_row(r), mem.img[r])
        $display("test %s done", name);
    endtask

    task automatic do_restore(input logic [31:0] v, input logic [31:0] m, input logic o);
        int n;
        logic [31:0] prev;
        mem.img[1][95:64] = v;
        mem.img[29] = ~FILL;
        vector_control_writable_mask = m;
        os_save_enable_bit = o;
        prev = restored_vector_control_status;
        state_restore_op = 1'b1;
        @(posedge clk);
        #1;
        state_restore_op = 1'b0;
        n = 0;
        while (restore_done !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK("restore_done", 1'b1, restore_done)
        `CHK("gp_fault", (v & ~m) != 32'h0, gp_fault)
        `CHK("restored", ((v & ~m) != 32'h0 || !o) ? prev : v, restored_vector_control_status)
        `CHK("read addr", image_base + 64'h10, mem.rd_addr_seen)
        $display("test restore %h done", v);
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        sys_rst = 1'b1;
        slow = 1'b0;
        {state_save_op, state_restore_op, operand_width_prefix_bit, mode64} = 4'h0;
        {addr16, os_save_enable_bit, packed_last} = 3'h0;
        image_base = 64'hFEDC_0000_0000_1200;
        fp_control_word = 16'h137F;
        fp_status_word = 16'h4A21;
        fp_full_tag = 16'hF3C8;
        last_fp_opcode = 11'h5A3;
        fp_instruction_pointer = 64'h89AB_CDEF_1234_5678;
        code_selector = 16'hC0DE;
        fp_operand_pointer = 64'h7654_3210_FEDC_BA98;
        data_selector = 16'h0D5E;
        vector_control_status = 32'h0000_1F80;
        vector_control_writable_mask = 32'h0000_FFBF;
        for (int i = 0; i < 8; i++) data_register_field[i] = {10{i[7:0] + 8'h10}};
        for (int i = 0; i < 16; i++) vector_register_field[i] = {16{i[7:0] + 8'h40}};
        repeat (10) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        `CHK("busy after reset", 1'b0, busy)
        `CHK("restored after reset", 32'h0, restored_vector_control_status)
        do_save("legacy", 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
        do_save("wide", 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
        do_save("narrow64", 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        slow = 1'b0;
        do_restore(32'h0000_1F80, 32'h0000_FFBF, 1'b1);
        slow = 1'b1;
        do_restore(32'h0001_0000, 32'h0000_FFBF, 1'b1);
        do_restore(32'h0000_0040, 32'h0000_FFBF, 1'b1);
        do_restore(32'h0000_0001, 32'h0000_FFBF, 1'b0);
        conclude();
    end

    // whole run needs a few hundred cycles; this leaves wide margin
    initial begin
        #500000;
        bad_count++;
        conclude();
    end
endmodule
`default_nettype wire
